// ==== hw/ctu_edge_chan.sv ====
// charge/time unit: one edge channel, source select and level polarity
`timescale 1ns/100ps
module ctu_edge_chan (
   input  wire ctu_pkg::ctu_src_t src_i,
   input  wire logic [1:0]        sel_i,
   input  wire logic              pol_i,
   output logic                   hit_o
);
   import ctu_pkg::*;

   logic lvl;

   ////////////////////////////////////////////////////////////////////////////
   // source mux: two pins, timer, output compare
   always_comb
   begin
      case (sel_i)
         CTU_SRC_PIN1:  lvl = src_i.pin[0];
         CTU_SRC_PIN2:  lvl = src_i.pin[1];
         CTU_SRC_TIMER: lvl = src_i.timer;
         CTU_SRC_OCMP:  lvl = src_i.ocmp;
         default:       lvl = 1'b0;
      endcase
   end

   // level, not transition: a matching level counts every cycle
   always_comb
   begin
      if (pol_i == CTU_POL_NEG)
      begin
         hit_o = ~lvl;
      end
      else
      begin
         hit_o = lvl;
      end
   end

endmodule

// ==== hw/ctu_top.sv ====
// charge/time unit: registers, edge status, current gating and completion flag
`timescale 1ns/100ps
module ctu_top #(
   parameter int ADDR_W = 5
) (
   input  wire logic              sys_clk_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire ctu_pkg::ctu_src_t src_i,
   output ctu_pkg::ctu_ana_t      ana_o,
   output logic                   irq_o
);
   import ctu_pkg::*;

   if (ADDR_W < CTU_ADDR_MIN)
   begin : g_chk
      $error("ADDR_W too small for the register map");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   ctu_bus_st_t bus_st_r;
   ctu_bus_st_t bus_st_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   ctu_icon_t   icon_r;
   ctu_icon_t   icon_nxt;
   ctu_low_t    low_r;
   ctu_low_t    low_nxt;
   ctu_high_t   high_r;
   ctu_high_t   high_nxt;
   logic        flag_r;
   logic        flag_nxt;
   logic        irq_en_r;
   logic        irq_en_nxt;
   logic        cur_q_r;
   logic        cur_q_nxt;
   ctu_ana_t    ana_r;
   ctu_ana_t    ana_nxt;
   logic        irq_r;
   logic        irq_nxt;

   logic        req;
   logic        acc;
   logic        wr_acc;
   logic [2:0]  idx;
   logic [7:0]  wd;
   logic [7:0]  rd_mux;
   logic        wr_icon;
   logic        wr_low;
   logic        wr_high;
   logic        wr_flag;
   logic        wr_irqen;
   logic        cur_on;
   logic        arm;
   logic [CTU_NCHAN-1:0] hit;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: every access takes one wait cycle, then completes
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & (bus_st_r == CTU_BUS_IDLE);
   assign acc               = req & (bus_st_r == CTU_BUS_ACK);
   assign wr_acc            = acc & avs_write_i & avs_byteenable_i[0];
   assign idx               = avs_address_i[CTU_ADDR_LSB +: 3];
   assign wd                = avs_writedata_i[7:0];
   assign wr_icon           = wr_acc & (idx == CTU_IDX_ICON);
   assign wr_low            = wr_acc & (idx == CTU_IDX_LOW);
   assign wr_high           = wr_acc & (idx == CTU_IDX_HIGH);
   assign wr_flag           = wr_acc & (idx == CTU_IDX_FLAG);
   assign wr_irqen          = wr_acc & (idx == CTU_IDX_IRQEN);
   assign avs_readdata_o    = rdata_r;

   // unmapped offsets read zero and ignore writes
   always_comb
   begin
      rd_mux = 8'h00;
      case (idx)
         CTU_IDX_ICON:  rd_mux = icon_r;
         CTU_IDX_LOW:   rd_mux = low_r;
         CTU_IDX_HIGH:  rd_mux = high_r;
         CTU_IDX_FLAG:  rd_mux[CTU_FLAG_BIT] = flag_r;
         CTU_IDX_IRQEN: rd_mux[CTU_IRQEN_BIT] = irq_en_r;
         default:       rd_mux = 8'h00;
      endcase
   end

   always_comb
   begin
      bus_st_nxt = bus_st_r;
      rdata_nxt  = rdata_r;
      case (bus_st_r)
         CTU_BUS_IDLE:
         begin
            if (req)
            begin
               bus_st_nxt = CTU_BUS_ACK;
            end
            // load in the wait cycle so data stand at the completing edge
            if (avs_read_i)
            begin
               rdata_nxt = {24'h000000, rd_mux};
            end
         end
         CTU_BUS_ACK:   bus_st_nxt = CTU_BUS_IDLE;
         default:       bus_st_nxt = CTU_BUS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         bus_st_r <= CTU_BUS_IDLE;
         rdata_r  <= 32'h00000000;
      end
      else
      begin
         bus_st_r <= bus_st_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge channels
   for (genvar c = 0; c < CTU_NCHAN; c++)
   begin : g_chan
      ctu_edge_chan u_chan (
         .src_i (src_i),
         .sel_i (c == 0 ? low_r.edge1_source_sel : low_r.edge2_source_sel),
         .pol_i (c == 0 ? low_r.edge1_polarity : low_r.edge2_polarity),
         .hit_o (hit[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration and edge status
   assign arm = high_r.unit_enable & high_r.edge_input_enable;

   always_comb
   begin
      icon_nxt   = icon_r;
      high_nxt   = high_r;
      low_nxt    = low_r;
      irq_en_nxt = irq_en_r;
      if (wr_icon)
      begin
         icon_nxt = wd;
      end
      if (wr_high)
      begin
         high_nxt         = wd;
         high_nxt.rsvd_hi = 2'h0;
         high_nxt.rsvd_lo = 1'b0;
      end
      if (wr_irqen)
      begin
         irq_en_nxt = wd[CTU_IRQEN_BIT];
      end
      if (wr_low)
      begin
         low_nxt = wd;
      end
      // a hardware set wins over a software clear in the same cycle
      if (arm && hit[0])
      begin
         low_nxt.edge1_status = 1'b1;
      end
      if (arm && hit[1] && (!high_r.edge_order_enable || low_r.edge1_status))
      begin
         low_nxt.edge2_status = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         icon_r   <= CTU_ICON_RST;
         low_r    <= CTU_LOW_RST;
         high_r   <= CTU_HIGH_RST;
         irq_en_r <= 1'b0;
      end
      else
      begin
         icon_r   <= icon_nxt;
         low_r    <= low_nxt;
         high_r   <= high_nxt;
         irq_en_r <= irq_en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // current gating and completion flag
   assign cur_on = high_r.unit_enable & (low_r.edge1_status ^ low_r.edge2_status);

   always_comb
   begin
      cur_q_nxt = cur_on;
      flag_nxt  = flag_r;
      // write one clears; a completion in the same cycle still wins
      if (wr_flag && wd[CTU_FLAG_BIT])
      begin
         flag_nxt = 1'b0;
      end
      if (cur_q_r && !cur_on)
      begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         cur_q_r <= 1'b0;
         flag_r  <= 1'b0;
      end
      else
      begin
         cur_q_r <= cur_q_nxt;
         flag_r  <= flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs to the analog side and the interrupt line
   always_comb
   begin
      ana_nxt            = '0;
      ana_nxt.cur_en     = cur_on;
      ana_nxt.range      = icon_r.current_range_sel;
      // passed as two's complement; the analog trim decodes the sign
      ana_nxt.trim       = icon_r.current_trim;
      ana_nxt.discharge  = high_r.unit_enable & high_r.discharge_enable;
      ana_nxt.adc_route  = high_r.unit_enable & ~high_r.delay_mode_select;
      ana_nxt.cmp2_route = high_r.unit_enable & high_r.delay_mode_select;
      irq_nxt            = flag_r & irq_en_r;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         ana_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         ana_r <= ana_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign ana_o = ana_r;
   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_cur_burst;
      cur_on ##1 !cur_on;
   endsequence

   sequence s_start_e1;
      wr_low && wd[1:0] == 2'b01 && high_r.unit_enable && !arm;
   endsequence

   property p_flag_on_off;
      s_cur_burst |=> flag_r;
   endproperty
   a_flag_on_off: assert property (p_flag_on_off)
      else $error("flag not set after current burst");

   property p_irq_gate;
      (flag_r && irq_en_r) |=> irq_o ##0 (!irq_en_r ##1 !irq_o or irq_en_r);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not raised from enabled flag");

   property p_irq_needs_en;
      !irq_en_r |=> !irq_o;
   endproperty
   a_irq_needs_en: assert property (p_irq_needs_en)
      else $error("interrupt raised while disabled");

   property p_one_stat;
      ana_o.cur_en |-> $past(low_r.edge1_status) != $past(low_r.edge2_status);
   endproperty
   a_one_stat: assert property (p_one_stat)
      else $error("current on without exactly one status bit");

   property p_sw_start;
      s_start_e1 |=> ##1 ana_o.cur_en;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("edge 1 status write did not start current");

   property p_unit_off;
      !high_r.unit_enable |=> !ana_o.cur_en && !ana_o.discharge;
   endproperty
   a_unit_off: assert property (p_unit_off)
      else $error("output active with unit disabled");

   property p_no_hw_set;
      (!arm && !wr_low) |=> $stable(low_r);
   endproperty
   a_no_hw_set: assert property (p_no_hw_set)
      else $error("status changed with edge inputs disabled");

   property p_order;
      (high_r.edge_order_enable && !low_r.edge1_status && !low_r.edge2_status && !wr_low)
         |=> !low_r.edge2_status;
   endproperty
   a_order: assert property (p_order)
      else $error("edge 2 accepted before edge 1");

   property p_flag_hold;
      (flag_r && !wr_flag) |=> flag_r [*2] or (flag_r ##1 wr_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag dropped without software clear");

   property p_hw_set;
      (arm && hit[0]) |=> low_r.edge1_status;
   endproperty
   a_hw_set: assert property (p_hw_set)
      else $error("edge 1 status not set by hardware");

   property p_disch;
      (wr_high && wd[7] && wd[1]) |=> ##1 ana_o.discharge;
   endproperty
   a_disch: assert property (p_disch)
      else $error("discharge not driven");

   property p_mode;
      high_r.unit_enable |=> (ana_o.adc_route != ana_o.cmp2_route);
   endproperty
   a_mode: assert property (p_mode)
      else $error("analog routing not exclusive");

endmodule

// ==== include/ctu_pkg.sv ====
// charge/time unit package: register map, field layouts, reset values and types
package ctu_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices on the bus, taken from the address bits from CTU_ADDR_LSB upward
   localparam logic [2:0] CTU_IDX_ICON  = 3'h0;
   localparam logic [2:0] CTU_IDX_LOW   = 3'h1;
   localparam logic [2:0] CTU_IDX_HIGH  = 3'h2;
   localparam logic [2:0] CTU_IDX_FLAG  = 3'h3;
   localparam logic [2:0] CTU_IDX_IRQEN = 3'h4;
   localparam int         CTU_ADDR_LSB  = 2;
   localparam int         CTU_ADDR_MIN  = 5;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and field positions
   localparam logic [7:0] CTU_ICON_RST  = 8'h00;
   localparam logic [7:0] CTU_LOW_RST   = 8'h00;
   localparam logic [7:0] CTU_HIGH_RST  = 8'h00;
   localparam int         CTU_FLAG_BIT  = 2;
   localparam int         CTU_IRQEN_BIT = 2;
   localparam int         CTU_ST1_BIT   = 0;
   localparam int         CTU_ST2_BIT   = 1;
   localparam int         CTU_NCHAN     = 2;

   // edge source select codes
   localparam logic [1:0] CTU_SRC_PIN1  = 2'h0;
   localparam logic [1:0] CTU_SRC_PIN2  = 2'h1;
   localparam logic [1:0] CTU_SRC_TIMER = 2'h2;
   localparam logic [1:0] CTU_SRC_OCMP  = 2'h3;
   // polarity: 0 active low level, 1 active high level
   localparam logic       CTU_POL_NEG   = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // register layouts, msb first
   typedef struct packed {
      logic [5:0] current_trim;
      logic [1:0] current_range_sel;
   } ctu_icon_t;

   typedef struct packed {
      logic       edge2_polarity;
      logic [1:0] edge2_source_sel;
      logic       edge1_polarity;
      logic [1:0] edge1_source_sel;
      logic       edge2_status;
      logic       edge1_status;
   } ctu_low_t;

   typedef struct packed {
      logic       unit_enable;
      logic [1:0] rsvd_hi;
      logic       delay_mode_select;
      logic       edge_input_enable;
      logic       edge_order_enable;
      logic       discharge_enable;
      logic       rsvd_lo;
   } ctu_high_t;

   // edge sources offered to both channels
   typedef struct packed {
      logic [1:0] pin;
      logic       timer;
      logic       ocmp;
   } ctu_src_t;

   // controls handed to the analog side
   typedef struct packed {
      logic       cur_en;
      logic [1:0] range;
      logic [5:0] trim;
      logic       discharge;
      logic       adc_route;
      logic       cmp2_route;
   } ctu_ana_t;

   typedef enum logic [1:0] {
      CTU_BUS_IDLE = 2'b01,
      CTU_BUS_ACK  = 2'b10
   } ctu_bus_st_t;

endpackage

// ==== testbench/ctu_src_model.sv ====
// edge source model: two trigger pins, timer and compare output as plain levels
`timescale 1ns/100ps
module ctu_src_model (
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic [3:0]  lvl_i,
   output ctu_pkg::ctu_src_t src_o
);
   import ctu_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // sources are synchronous, so levels move only on the clock edge
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         src_o <= '0;
      else
         src_o <= ctu_src_t'(lvl_i);
   end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the charge/time unit: bus tasks and register-level tests
`timescale 1ns/100ps
module tb_top;
   import ctu_pkg::*;
   logic        sys_clk_i;
   logic        srst_i;
   logic [4:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   ctu_src_t    src_w;
   ctu_ana_t    ana_o;
   logic        irq_o;
   logic [3:0]  src_lvl;
   logic [31:0] rd;
   logic [7:0]  v;
   logic [7:0]  icon_tab [3];
   int          n_errors;
   int          checks;
   int          cyc_cnt;

   ctu_top #(.ADDR_W(5)) u_dut (
      .sys_clk_i        (sys_clk_i),
      .srst_i           (srst_i),
      .avs_address_i    (avs_address_i),
      .avs_read_i       (avs_read_i),
      .avs_write_i      (avs_write_i),
      .avs_writedata_i  (avs_writedata_i),
      .avs_byteenable_i (avs_byteenable_i),
      .avs_readdata_o   (avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .src_i            (src_w),
      .ana_o            (ana_o),
      .irq_o            (irq_o)
   );

   ctu_src_model u_src (
      .sys_clk_i(sys_clk_i),
      .srst_i   (srst_i),
      .lvl_i    (src_lvl),
      .src_o    (src_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // whole run needs a few hundred cycles; far above that means a hang
   always @(posedge sys_clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt >= 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one avalon transfer; request held until waitrequest is sampled low at a rising edge,
   // read data taken at that same edge; only the bench timeout ends a stuck wait
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= {24'h0, d};
      avs_read_i      <= !wr;
      avs_write_i     <= wr;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0)
      begin
         @(posedge sys_clk_i);
      end
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h0, exp});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   function automatic logic [3:0] src_mask(input logic [1:0] s);
      case (s)
         2'h0:    return 4'h4;
         2'h1:    return 4'h8;
         2'h2:    return 4'h2;
         default: return 4'h1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst_i           = 1'b1;
      avs_address_i    = 5'h00;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h0;
      avs_byteenable_i = 4'h1;
      src_lvl          = 4'h0;
      n_errors         = 0;
      checks           = 0;
      cyc_cnt          = 0;
      icon_tab         = '{8'h01, 8'h82, 8'h7f};
      repeat (12) @(posedge sys_clk_i);
      srst_i <= 1'b0;

      for (int i = 0; i < 5; i++)
         rdchk(5'(i * 4), 8'h00);
      bus(1'b1, 5'h14, 8'hff);
      rdchk(5'h14, 8'h00);
      // a write without the low byte lane enabled must leave the register alone
      avs_byteenable_i <= 4'he;
      bus(1'b1, 5'h00, 8'hff);
      avs_byteenable_i <= 4'h1;
      rdchk(5'h00, 8'h00);
      chk({20'h0, ana_o}, 32'h0);
      $display("test reset done");

      for (int i = 0; i < 3; i++)
      begin
         v = icon_tab[i];
         bus(1'b1, 5'h00, v);
         settle(1);
         chk({30'h0, ana_o.range}, {30'h0, v[1:0]});
         chk({26'h0, ana_o.trim}, {26'h0, v[7:2]});
      end
      $display("test current control done");

      bus(1'b1, 5'h08, 8'h80);
      settle(1);
      chk({29'h0, ana_o.adc_route, ana_o.cmp2_route, ana_o.discharge}, 32'h4);
      bus(1'b1, 5'h08, 8'h92);
      settle(1);
      chk({29'h0, ana_o.adc_route, ana_o.cmp2_route, ana_o.discharge}, 32'h3);
      bus(1'b1, 5'h08, 8'h12);
      settle(1);
      chk({29'h0, ana_o.adc_route, ana_o.cmp2_route, ana_o.discharge}, 32'h0);
      $display("test mode and discharge done");

      // discharge cleared before charging starts
      bus(1'b1, 5'h08, 8'h80);
      bus(1'b1, 5'h10, 8'h04);
      bus(1'b1, 5'h04, 8'h01);
      settle(2);
      chk({31'h0, ana_o.cur_en}, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b1, 5'h04, 8'h03);
      settle(2);
      chk({31'h0, ana_o.cur_en}, 32'h0);
      settle(2);
      chk({31'h0, irq_o}, 32'h1);
      settle(20);
      rdchk(5'h0c, 8'h04);
      bus(1'b1, 5'h10, 8'h00);
      settle(2);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b1, 5'h0c, 8'h04);
      rdchk(5'h0c, 8'h00);
      $display("test software current and flag done");

      // per source: disable unit, configure, re-enable, clear both statuses, then open edges
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, 5'h08, 8'h00);
         src_lvl <= 4'h0;
         bus(1'b1, 5'h04, {1'b1, 2'(s), 1'b1, 2'(s), 2'b00});
         bus(1'b1, 5'h08, 8'h80);
         bus(1'b1, 5'h04, {1'b1, 2'(s), 1'b1, 2'(s), 2'b00});
         src_lvl <= src_mask(2'(s));
         settle(3);
         rdchk(5'h04, {1'b1, 2'(s), 1'b1, 2'(s), 2'b00});
         bus(1'b1, 5'h08, 8'h88);
         settle(3);
         rdchk(5'h04, {1'b1, 2'(s), 1'b1, 2'(s), 2'b11});
      end
      $display("test edge sources done");

      // low-level polarity, edge 2 level present first but ordering holds it back
      bus(1'b1, 5'h08, 8'h80);
      src_lvl <= 4'h7;
      bus(1'b1, 5'h04, 8'h20);
      bus(1'b1, 5'h08, 8'h8c);
      settle(3);
      rdchk(5'h04, 8'h20);
      src_lvl <= 4'h3;
      settle(3);
      rdchk(5'h04, 8'h23);
      bus(1'b1, 5'h08, 8'h00);
      settle(2);
      chk({31'h0, ana_o.cur_en}, 32'h0);
      $display("test polarity and ordering done");
      tally_and_finish();
   end
endmodule
